/* File: plc_params.svh */
/*
  Constants of the 10/100 line codec: register offsets, field positions,
  reset values, code words and timing counts.
  Assumes a 40 MHz pclk; included by its bare name.
*/
`ifndef PLC_PARAMS_SVH
`define PLC_PARAMS_SVH

// Register map (byte addresses)
`define PLC_CTRL_ADDR 12'h000
`define PLC_STAT_ADDR 12'h004
// Control fields
`define PLC_CTRL_SPEED100 0
`define PLC_CTRL_BYPASS 1
`define PLC_CTRL_RESET 2'h1
// Status fields
`define PLC_STAT_SSD 0
`define PLC_STAT_ESD 1
`define PLC_STAT_CODE 2
`define PLC_STAT_LOS 3
`define PLC_STAT_LOCK 4
// Line code words
`define PLC_SYM_I 5'h1f
`define PLC_SYM_J 5'h18
`define PLC_SYM_K 5'h11
`define PLC_SYM_T 5'h0d
`define PLC_SYM_R 5'h07
`define PLC_SYM_H 5'h04
`define PLC_NIB_SSD 4'h5
`define PLC_NIB_ZERO 4'h0
// Timing
`define PLC_CLK_KHZ 40000
`define PLC_SYNC_WINDOW_MS 1
`define PLC_SYNC_WINDOW_CYC (`PLC_SYNC_WINDOW_MS * `PLC_CLK_KHZ)
`define PLC_LINK_PULSE_MS 16
`define PLC_LINK_PULSE_CYC (`PLC_LINK_PULSE_MS * `PLC_CLK_KHZ)
`define PLC_IDLE_ONES 25
`define PLC_ACQ_MATCH 30
`define PLC_LOCK_BITS 12
`define PLC_LFSR_SEED 11'h7ff
`define PLC_SOI_CELLS 4

`endif

/* File: plc_pkg.sv */
/*
  Types of the 10/100 line codec: state machine encodings.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package plc_pkg;

  // Transmit symbol sequencer, one-hot
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_K = 4'b0010,
    TX_DATA = 4'b0100,
    TX_R = 4'b1000
  } plc_tx_state_t;

  // Receive delimiter tracker, one-hot
  typedef enum logic [3:0] {
    RX_HUNT = 4'b0001,
    RX_K = 4'b0010,
    RX_DATA = 4'b0100,
    RX_R = 4'b1000
  } plc_rx_state_t;

endpackage : plc_pkg

/* File: plc_line_codec.sv */
/*
  Digital line codec of a 10/100 PHY: 4B5B coding, scrambling, descrambler
  sync, Manchester coding, nibble recovery, APB control/status.
  Assumes the MAC drives tx nibbles on media_tx_clock (outside pclk), and
  the line receiver front end gives bits with a strobe on pclk.
*/
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "plc_params.svh"

module plc_line_codec #(
  parameter int SYNC_WINDOW_CYCLES = `PLC_SYNC_WINDOW_CYC,
  parameter int LINK_PULSE_CYCLES = `PLC_LINK_PULSE_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // MAC transmit side
  input wire logic media_tx_clock,
  input wire logic mac_tx_en,
  input wire logic [3:0] mac_tx_data,
  // MAC receive side
  output logic media_rx_clock,
  output logic mac_rx_dv,
  output logic mac_rx_er,
  output logic [3:0] mac_rx_data,
  // Line transmitter
  output logic line_tx_bit,
  output logic line_tx_strobe,
  // Line receiver
  input wire logic line_rx_bit,
  input wire logic line_rx_strobe,
  input wire logic squelch_ok,
  input wire logic eq_settled
);

  localparam int SWW = $clog2(SYNC_WINDOW_CYCLES + 1);
  localparam int LPW = $clog2(LINK_PULSE_CYCLES + 1);

  // 4B5B encode table
  function automatic logic [4:0] enc_sym(input logic [3:0] n);
    case (n)
      4'h0: enc_sym = 5'h1e;
      4'h1: enc_sym = 5'h09;
      4'h2: enc_sym = 5'h14;
      4'h3: enc_sym = 5'h15;
      4'h4: enc_sym = 5'h0a;
      4'h5: enc_sym = 5'h0b;
      4'h6: enc_sym = 5'h0e;
      4'h7: enc_sym = 5'h0f;
      4'h8: enc_sym = 5'h12;
      4'h9: enc_sym = 5'h13;
      4'ha: enc_sym = 5'h16;
      4'hb: enc_sym = 5'h17;
      4'hc: enc_sym = 5'h1a;
      4'hd: enc_sym = 5'h1b;
      4'he: enc_sym = 5'h1c;
      default: enc_sym = 5'h1d;
    endcase
  endfunction : enc_sym

  // Data decode by reverse search; bit 4 marks a data code word
  function automatic logic [4:0] dec_sym(input logic [4:0] s);
    dec_sym = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (enc_sym(4'(i)) == s) begin
        dec_sym = {1'b1, 4'(i)};
      end
    end
  endfunction : dec_sym

  // Manchester cells of a nibble, LSB bit first, complement half first
  function automatic logic [7:0] manch(input logic [3:0] n);
    manch = {~n[0], n[0], ~n[1], n[1], ~n[2], n[2], ~n[3], n[3]};
  endfunction : manch

  // Two-flop synchronisers for pins outside pclk
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic txc_d_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
      txc_d_r <= 1'b0;
    end else begin
      sync1_r <= {eq_settled, squelch_ok, mac_tx_data, mac_tx_en,
                  media_tx_clock};
      sync2_r <= sync1_r;
      txc_d_r <= sync2_r[0];
    end
  end

  wire txc_s = sync2_r[0];
  wire tx_en_s = sync2_r[1];
  wire [3:0] tx_d_s = sync2_r[5:2];
  wire sq_s = sync2_r[6];
  wire eq_s = sync2_r[7];
  wire nib_evt = txc_s & ~txc_d_r;

  // Control register
  logic [1:0] ctrl_r;
  wire speed100 = ctrl_r[`PLC_CTRL_SPEED100];
  wire bypass = ctrl_r[`PLC_CTRL_BYPASS];
  wire lock = sq_s & (eq_s | ~speed100);

  // Transmit sequencer selection
  plc_pkg::plc_tx_state_t tx_st_r;
  plc_pkg::plc_tx_state_t tx_st_nxt;
  logic [7:0] tx_sh_r;
  logic [3:0] tx_cnt_r;
  logic [10:0] tx_lfsr_r;
  logic [LPW-1:0] lp_cnt_r;
  logic tx_load;
  logic [7:0] tx_load_val;
  logic [3:0] tx_load_cnt;
  wire lp_due = (lp_cnt_r == '0);

  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_load = 1'b0;
    tx_load_val = 8'h00;
    tx_load_cnt = 4'h5;
    if (nib_evt && speed100) begin
      tx_load = 1'b1;
      case (tx_st_r)
        plc_pkg::TX_IDLE: begin
          if (tx_en_s) begin
            tx_load_val = {`PLC_SYM_J, 3'h0};
            tx_st_nxt = plc_pkg::TX_K;
          end else begin
            tx_load_val = {`PLC_SYM_I, 3'h0};
          end
        end
        plc_pkg::TX_K: begin
          tx_load_val = {`PLC_SYM_K, 3'h0};
          tx_st_nxt = plc_pkg::TX_DATA;
        end
        plc_pkg::TX_DATA: begin
          if (tx_en_s) begin
            tx_load_val = {enc_sym(tx_d_s), 3'h0};
          end else begin
            tx_load_val = {`PLC_SYM_T, 3'h0};
            tx_st_nxt = plc_pkg::TX_R;
          end
        end
        plc_pkg::TX_R: begin
          tx_load_val = {`PLC_SYM_R, 3'h0};
          tx_st_nxt = plc_pkg::TX_IDLE;
        end
        default: tx_st_nxt = plc_pkg::TX_IDLE;
      endcase
    end else if (nib_evt) begin
      tx_load_cnt = 4'h8;
      if (tx_en_s) begin
        tx_load = 1'b1;
        tx_load_val = manch(tx_d_s);
        tx_st_nxt = plc_pkg::TX_DATA;
      end else if (tx_st_r != plc_pkg::TX_IDLE) begin
        // Start-of-idle: line held high, then released
        tx_load = 1'b1;
        tx_load_val = 8'hf0;
        tx_load_cnt = 4'(`PLC_SOI_CELLS);
        tx_st_nxt = plc_pkg::TX_IDLE;
      end
    end else if (!speed100 && tx_st_r == plc_pkg::TX_IDLE && lp_due &&
                 tx_cnt_r == 4'h0) begin
      // Idle gap carries only a lone link pulse
      tx_load = 1'b1;
      tx_load_val = 8'h80;
      tx_load_cnt = 4'h1;
    end
  end

  // Scrambler key, only used at 100M outside bypass
  wire tx_key = tx_lfsr_r[10] ^ tx_lfsr_r[8];
  wire tx_scr_on = speed100 & ~bypass;
  wire tx_shift = (tx_cnt_r != 4'h0);
  wire tx_out = tx_scr_on ? (tx_sh_r[7] ^ tx_key) : tx_sh_r[7];

  // Serialiser, leftmost bit first, one bit per pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_r <= plc_pkg::TX_IDLE;
      tx_sh_r <= 8'h00;
      tx_cnt_r <= 4'h0;
      tx_lfsr_r <= `PLC_LFSR_SEED;
      line_tx_bit <= 1'b0;
      line_tx_strobe <= 1'b0;
    end else begin
      tx_st_r <= tx_st_nxt;
      line_tx_strobe <= tx_shift;
      line_tx_bit <= tx_shift & tx_out;
      if (tx_shift && tx_scr_on) begin
        tx_lfsr_r <= {tx_lfsr_r[9:0], tx_key};
      end
      if (tx_load) begin
        tx_sh_r <= tx_load_val;
        tx_cnt_r <= tx_load_cnt;
      end else if (tx_shift) begin
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        tx_cnt_r <= tx_cnt_r - 4'h1;
      end
    end
  end

  // Link pulse interval timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_cnt_r <= LPW'(LINK_PULSE_CYCLES - 1);
    end else if (lp_due || speed100) begin
      lp_cnt_r <= LPW'(LINK_PULSE_CYCLES - 1);
    end else begin
      lp_cnt_r <= lp_cnt_r - LPW'(1);
    end
  end

  // Descrambler
  logic [10:0] rx_lfsr_r;
  logic synced_r;
  logic seen_r;
  logic [5:0] acq_cnt_r;
  logic [4:0] ones_r;
  logic [SWW-1:0] win_cnt_r;
  wire st100 = line_rx_strobe & speed100;
  wire rx_key = rx_lfsr_r[10] ^ rx_lfsr_r[8];
  wire acq_match = (~line_rx_bit) == rx_key;
  wire dbit = bypass ? line_rx_bit : line_rx_bit ^ rx_key;
  wire sync_ok = synced_r | bypass;
  wire win_end = (win_cnt_r == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_lfsr_r <= `PLC_LFSR_SEED;
      acq_cnt_r <= 6'h00;
      synced_r <= 1'b0;
    end else if (st100) begin
      rx_lfsr_r <= {rx_lfsr_r[9:0], synced_r ? rx_key : ~line_rx_bit};
      if (!synced_r) begin
        // Idle assumed: key equals inverted line bit
        acq_cnt_r <= acq_match ? acq_cnt_r + 6'h01 : 6'h00;
        if (acq_match && acq_cnt_r == 6'(`PLC_ACQ_MATCH - 1)) begin
          synced_r <= 1'b1;
        end
      end else if (win_end && !seen_r) begin
        synced_r <= 1'b0;
        acq_cnt_r <= 6'h00;
      end
    end else if (synced_r && win_end && !seen_r) begin
      synced_r <= 1'b0;
      acq_cnt_r <= 6'h00;
    end
  end

  // Idle-ones watch over each sync window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ones_r <= 5'h00;
      seen_r <= 1'b0;
      win_cnt_r <= SWW'(SYNC_WINDOW_CYCLES - 1);
    end else begin
      win_cnt_r <= (win_end || !synced_r) ?
                   SWW'(SYNC_WINDOW_CYCLES - 1) : win_cnt_r - SWW'(1);
      if (st100) begin
        ones_r <= dbit ? ((ones_r == 5'h1f) ? ones_r : ones_r + 5'h01)
                       : 5'h00;
      end
      if (win_end || !synced_r) begin
        seen_r <= 1'b0;
      end else if (st100 && dbit && ones_r == 5'(`PLC_IDLE_ONES - 1)) begin
        seen_r <= 1'b1;
      end
    end
  end

  // Symbol alignment and 4B5B decode
  plc_pkg::plc_rx_state_t rx_st_r;
  plc_pkg::plc_rx_state_t rx_st_nxt;
  logic [9:0] rx_win_r;
  logic [2:0] bit_cnt_r;
  logic [3:0] lock_cnt_r;
  logic [3:0] nib_acc_r;
  wire [9:0] win_new = {rx_win_r[8:0], dbit};
  wire [4:0] sym = win_new[4:0];
  wire [4:0] dec = dec_sym(sym);
  wire j_det = st100 & sync_ok & (rx_st_r == plc_pkg::RX_HUNT) &
               (win_new == {`PLC_SYM_I, `PLC_SYM_J});
  wire sym_done = st100 & (bit_cnt_r == 3'h4) & ~j_det;
  wire locked10 = (lock_cnt_r == 4'(`PLC_LOCK_BITS));
  wire st10 = line_rx_strobe & ~speed100 & lock;
  wire nib10 = st10 & locked10 & (bit_cnt_r == 3'h3);

  logic emit;
  logic [3:0] e_data;
  logic e_dv;
  logic e_er;
  logic [2:0] e_err;
  always_comb begin
    rx_st_nxt = rx_st_r;
    emit = j_det | sym_done | nib10;
    e_data = `PLC_NIB_ZERO;
    e_dv = 1'b0;
    e_er = 1'b0;
    e_err = 3'h0;
    if (j_det) begin
      e_data = `PLC_NIB_SSD;
      e_dv = 1'b1;
      rx_st_nxt = plc_pkg::RX_K;
    end else if (nib10) begin
      e_data = {line_rx_bit, nib_acc_r[3:1]};
      e_dv = 1'b1;
    end else if (sym_done && !sync_ok) begin
      rx_st_nxt = plc_pkg::RX_HUNT;
    end else if (sym_done) begin
      e_dv = (rx_st_r != plc_pkg::RX_HUNT);
      case (rx_st_r)
        plc_pkg::RX_HUNT: rx_st_nxt = plc_pkg::RX_HUNT;
        plc_pkg::RX_K: begin
          if (sym == `PLC_SYM_K) begin
            e_data = `PLC_NIB_SSD;
            rx_st_nxt = plc_pkg::RX_DATA;
          end else begin
            e_er = 1'b1;
            e_err[`PLC_STAT_SSD] = 1'b1;
            rx_st_nxt = plc_pkg::RX_HUNT;
          end
        end
        plc_pkg::RX_DATA: begin
          if (sym == `PLC_SYM_T) begin
            rx_st_nxt = plc_pkg::RX_R;
          end else if (sym == `PLC_SYM_I) begin
            e_er = 1'b1;
            e_err[`PLC_STAT_ESD] = 1'b1;
            rx_st_nxt = plc_pkg::RX_HUNT;
          end else if (dec[4]) begin
            e_data = dec[3:0];
          end else begin
            // Halt and unused codes carry no data
            e_er = 1'b1;
            e_err[`PLC_STAT_CODE] = 1'b1;
          end
        end
        plc_pkg::RX_R: begin
          rx_st_nxt = plc_pkg::RX_HUNT;
          if (sym != `PLC_SYM_R) begin
            e_er = 1'b1;
            e_err[`PLC_STAT_ESD] = 1'b1;
          end
        end
        default: rx_st_nxt = plc_pkg::RX_HUNT;
      endcase
    end
  end

  // Receive bit counters and nibble assembly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r <= plc_pkg::RX_HUNT;
      rx_win_r <= 10'h000;
      bit_cnt_r <= 3'h0;
      lock_cnt_r <= 4'h0;
      nib_acc_r <= 4'h0;
    end else begin
      rx_st_r <= speed100 ? rx_st_nxt : plc_pkg::RX_HUNT;
      if (st100) begin
        rx_win_r <= win_new;
        bit_cnt_r <= (j_det || bit_cnt_r == 3'h4) ? 3'h0 : bit_cnt_r + 3'h1;
      end else if (st10 && locked10) begin
        nib_acc_r <= {line_rx_bit, nib_acc_r[3:1]};
        bit_cnt_r <= (bit_cnt_r == 3'h3) ? 3'h0 : bit_cnt_r + 3'h1;
      end else if (st10) begin
        lock_cnt_r <= lock_cnt_r + 4'h1;
        bit_cnt_r <= 3'h0;
      end
      if (!lock && !speed100) begin
        lock_cnt_r <= 4'h0;
      end
    end
  end

  // MAC receive outputs and recovered clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_rx_data <= 4'h0;
      mac_rx_dv <= 1'b0;
      mac_rx_er <= 1'b0;
      media_rx_clock <= 1'b0;
    end else begin
      if (emit) begin
        mac_rx_data <= e_data;
        mac_rx_dv <= e_dv;
        mac_rx_er <= e_er;
      end else if (!lock) begin
        mac_rx_dv <= 1'b0;
        mac_rx_er <= 1'b0;
      end
      if (!lock) begin
        media_rx_clock <= txc_s;
      end else if (emit) begin
        media_rx_clock <= 1'b0;
      end else if (line_rx_strobe && bit_cnt_r == 3'h2) begin
        media_rx_clock <= 1'b1;
      end
    end
  end

  // APB: zero wait, answer prepared in the setup cycle
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire hit_ctrl = (paddr == `PLC_CTRL_ADDR);
  wire hit_stat = (paddr == `PLC_STAT_ADDR);
  // Loss-of-sync is a live level of the descrambler state
  wire los = ~sync_ok;
  wire [31:0] stat_word = {27'h0, locked10 | (lock & speed100), los,
                           3'h0};
  logic [2:0] err_r;
  wire [2:0] err_clr = (access && pwrite && hit_stat) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      ctrl_r <= `PLC_CTRL_RESET;
      err_r <= 3'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit_ctrl & ~hit_stat;
      if (setup && !pwrite) begin
        prdata <= hit_ctrl ? {30'h0, ctrl_r} :
                  hit_stat ? (stat_word | {29'h0, err_r}) : 32'h0000_0000;
      end
      if (access && pwrite && hit_ctrl) begin
        ctrl_r <= pwdata[1:0];
      end
      // Sticky errors: a new error beats a same-cycle clear
      err_r <= (err_r & ~err_clr) | e_err;
    end
  end

endmodule : plc_line_codec

/* File: plc_mac_model.sv */
/*
  Behavioural MAC transmit side: free-running nibble clock and packets.
  Assumes the codec samples these levels on its own pclk.
*/
`timescale 1ns/1ps
module plc_mac_model (
  // Nibble interface toward the codec
  output logic media_tx_clock,
  output logic mac_tx_en,
  output logic [3:0] mac_tx_data
);
  initial media_tx_clock = 1'h0;
  initial mac_tx_en = 1'h0;
  initial mac_tx_data = 4'h0;

  // Nibble clock runs free, as a media clock does between frames
  always #100 media_tx_clock = ~media_tx_clock;

  // One packet, launched on nibble clock rising edges
  task automatic send(input logic [3:0] nibs[$]);
    foreach (nibs[i]) begin
      @(posedge media_tx_clock);
      mac_tx_en <= 1'h1;
      mac_tx_data <= nibs[i];
    end
    @(posedge media_tx_clock);
    mac_tx_en <= 1'h0;
    mac_tx_data <= ~mac_tx_data; // Stale data must not look valid
    repeat (6) @(posedge media_tx_clock);
  endtask : send
endmodule : plc_mac_model

/* File: plc_line_codec_checker.sv */
/*
  Port-level assertions for the line codec.
  Assumes it is bound to plc_line_codec and sees only its ports.
*/
`timescale 1ns/1ps
module plc_line_codec_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // MAC side
  input wire logic media_tx_clock,
  input wire logic mac_tx_en,
  input wire logic media_rx_clock,
  input wire logic [3:0] mac_rx_data,
  // Line side
  input wire logic line_tx_bit,
  input wire logic line_tx_strobe,
  input wire logic squelch_ok
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Steps of an APB transfer and of a quiet line
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_quiet;
    !squelch_ok [*8];
  endsequence

  AST_APB_READY_NEXT: assert property (
    s_setup |=> pready && penable)
    else $error("no ready after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_SLVERR_READY: assert property (
    pslverr |-> pready && prdata == 32'h0)
    else $error("bad refusal");
  AST_TXBIT_QUIET: assert property (!line_tx_strobe |-> !line_tx_bit)
    else $error("line bit without strobe");
  AST_TX_START: assert property ($rose(media_tx_clock) && mac_tx_en
    |-> ##[2:7] line_tx_strobe)
    else $error("no line bits after nibble");
  AST_RXCLK_TRACK: assert property (s_quiet ##0 $rose(media_tx_clock)
    |-> ##[1:6] $rose(media_rx_clock))
    else $error("rx clock not tracking tx clock");
  AST_RXDATA_ON_FALL: assert property ($changed(mac_rx_data)
    |-> !media_rx_clock)
    else $error("rx data moved with clock high");
endmodule : plc_line_codec_checker

bind plc_line_codec plc_line_codec_checker u_plc_line_codec_checker (
  .pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
  .media_tx_clock, .mac_tx_en, .media_rx_clock, .mac_rx_data,
  .line_tx_bit, .line_tx_strobe, .squelch_ok
);

/* File: phy_line_codec_10_100_bench.sv */
/*
  Self-checking bench for the line codec: APB, 100M and 10M transmit,
  100M receive with bypass. Assumes plc_mac_model and the checker.
*/
`timescale 1ns/1ps
`include "plc_params.svh"
module phy_line_codec_10_100_bench;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic media_tx_clock;
  logic mac_tx_en;
  logic [3:0] mac_tx_data;
  logic media_rx_clock;
  logic mac_rx_dv;
  logic mac_rx_er;
  logic [3:0] mac_rx_data;
  logic line_tx_bit;
  logic line_tx_strobe;
  logic line_rx_bit = 1'h0;
  logic line_rx_strobe = 1'h0;
  logic squelch_ok = 1'h0;
  logic eq_settled = 1'h0;
  int n_errors = 0;
  int comparisons = 0;
  logic [31:0] rq;
  logic re;
  logic txq[$];
  logic [4:0] rxq[$];
  // Data code words 0..F, five bits each
  localparam logic [79:0] C45 = {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16,
    5'h13, 5'h12, 5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};

  always #12.5 pclk = ~pclk;

  plc_line_codec #(.SYNC_WINDOW_CYCLES(300), .LINK_PULSE_CYCLES(50))
    u_plc_line_codec (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .media_tx_clock, .mac_tx_en,
    .mac_tx_data, .media_rx_clock, .mac_rx_dv, .mac_rx_er, .mac_rx_data,
    .line_tx_bit, .line_tx_strobe, .line_rx_bit, .line_rx_strobe,
    .squelch_ok, .eq_settled);
  plc_mac_model u_plc_mac_model (.media_tx_clock, .mac_tx_en, .mac_tx_data);

  // Monitors: line bits on strobes, nibbles on recovered clock
  always @(posedge pclk)
    if (line_tx_strobe === 1'h1) txq.push_back(line_tx_bit);
  always @(posedge media_rx_clock)
    if (mac_rx_dv === 1'h1) rxq.push_back({mac_rx_er, mac_rx_data});

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask : chk_flag

  // One APB transfer; read data and error land in rq and re
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      $display("[ERR] %0t apb no ready", $time);
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  function automatic void push5(ref logic q[$], input logic [4:0] c);
    for (int i = 4; i >= 0; i--) q.push_back(c[i]);
  endfunction : push5

  // True when the expected bit run occurs in the captured line bits
  function automatic logic has(logic e[$]);
    for (int s = 0; s + e.size() <= txq.size(); s++) begin
      int k = 0;
      while (k < e.size() && txq[s + k] === e[k]) k++;
      if (k == e.size()) return 1'h1;
    end
    return 1'h0;
  endfunction : has

  // One received code word, leftmost bit first, bit line busy between
  task automatic sym(input logic [4:0] c);
    for (int i = 4; i >= 0; i--) begin
      @(posedge pclk);
      line_rx_bit <= c[i];
      line_rx_strobe <= 1'h1;
      @(posedge pclk);
      line_rx_strobe <= 1'h0;
      line_rx_bit <= ~c[i];
      repeat (2) @(posedge pclk);
    end
  endtask : sym

  task automatic t_regs;
    apb(1'h0, `PLC_CTRL_ADDR, 32'h0);
    chk_word(rq, 32'h1);
    apb(1'h0, `PLC_STAT_ADDR, 32'h0);
    chk_flag(rq[`PLC_STAT_LOS], 1'h1);
    apb(1'h0, 12'h008, 32'h0);
    chk_flag(re, 1'h1);
    chk_word(rq, 32'h0);
  endtask : t_regs

  // 100M packet, bypassed then scrambled
  task automatic t_tx100;
    logic e[$];
    logic [3:0] nb[$];
    nb = {4'h5, 4'h5, 4'h0, 4'h1, 4'ha, 4'hf};
    push5(e, `PLC_SYM_I);
    push5(e, `PLC_SYM_J);
    push5(e, `PLC_SYM_K);
    for (int i = 2; i < 6; i++) push5(e, C45[nb[i] * 5 +: 5]);
    push5(e, `PLC_SYM_T);
    push5(e, `PLC_SYM_R);
    push5(e, `PLC_SYM_I);
    apb(1'h1, `PLC_CTRL_ADDR, 32'h3);
    txq = {};
    u_plc_mac_model.send(nb);
    chk_flag(has(e), 1'h1);
    apb(1'h1, `PLC_CTRL_ADDR, 32'h1);
    txq = {};
    u_plc_mac_model.send(nb);
    chk_flag(has(e), 1'h0);
  endtask : t_tx100

  // 100M receive through bypass, clean then with a halt code
  task automatic t_rx100;
    logic [4:0] ex[$];
    int ers;
    ex = {5'h05, 5'h05, 5'h00, 5'h01, 5'h00, 5'h00};
    apb(1'h1, `PLC_CTRL_ADDR, 32'h3);
    squelch_ok <= 1'h1;
    eq_settled <= 1'h1;
    rxq = {};
    repeat (6) sym(`PLC_SYM_I);
    sym(`PLC_SYM_J);
    sym(`PLC_SYM_K);
    sym(C45[4:0]);
    sym(C45[9:5]);
    sym(`PLC_SYM_T);
    sym(`PLC_SYM_R);
    repeat (4) sym(`PLC_SYM_I);
    chk_word(rxq.size(), 32'd6);
    foreach (ex[i]) chk_word(rxq[i], ex[i]);
    rxq = {};
    repeat (4) sym(`PLC_SYM_I);
    sym(`PLC_SYM_J);
    sym(`PLC_SYM_K);
    sym(`PLC_SYM_H);
    sym(`PLC_SYM_T);
    sym(`PLC_SYM_R);
    repeat (4) sym(`PLC_SYM_I);
    ers = 0;
    foreach (rxq[i]) if (rxq[i] === 5'h10) ers++;
    chk_word(ers, 32'd1);
    apb(1'h0, `PLC_STAT_ADDR, 32'h0);
    chk_word(rq[2:0], 3'h4);
    apb(1'h1, `PLC_STAT_ADDR, 32'h4);
    apb(1'h0, `PLC_STAT_ADDR, 32'h0);
    chk_flag(rq[`PLC_STAT_CODE], 1'h0);
    squelch_ok <= 1'h0;
    eq_settled <= 1'h0;
  endtask : t_rx100

  // 10M packet of one nibble, then idle link pulses
  task automatic t_tx10;
    logic e[$];
    logic [3:0] nb[$];
    nb = {4'h6};
    for (int b = 0; b < 4; b++) begin
      e.push_back(~nb[0][b]);
      e.push_back(nb[0][b]);
    end
    repeat (4) e.push_back(1'h1);
    apb(1'h1, `PLC_CTRL_ADDR, 32'h0);
    txq = {};
    u_plc_mac_model.send(nb);
    chk_flag(has(e), 1'h1);
    txq = {};
    repeat (200) @(posedge pclk);
    chk_flag(txq.size() >= 3 && txq.size() <= 5, 1'h1);
  endtask : t_tx10

  // 10M receive: 12 lock bits are lost, then nibbles LSB first
  task automatic t_rx10;
    logic [11:0] nb;
    nb = 12'h3a5;
    squelch_ok <= 1'h1;
    rxq = {};
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 24; i++) begin
      @(posedge pclk);
      line_rx_bit <= (i < 12) ? i[0] : nb[i - 12];
      line_rx_strobe <= 1'h1;
      @(posedge pclk);
      line_rx_strobe <= 1'h0;
      repeat (2) @(posedge pclk);
    end
    // Third nibble is never clocked out, so two entries are seen
    chk_word(rxq.size(), 32'd2);
    chk_word(rxq[0], 5'h05);
    chk_word(rxq[1], 5'h0a);
    squelch_ok <= 1'h0;
  endtask : t_rx10

  task automatic summarize;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    repeat (4) @(posedge pclk);
    t_regs;
    t_tx100;
    t_rx100;
    t_tx10;
    t_rx10;
    summarize;
  end

  // Watchdog, well beyond the expected run
  initial begin
    #500000;
    n_errors++;
    summarize;
  end
endmodule : phy_line_codec_10_100_bench
